// File: flash_ctl_pkg.sv
// Constants and types for the host-side flash erase/write sequencer.
// Assumes a parallel flash with a command interface on an 8-bit data path.
package flash_ctl_pkg;
  localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_BLOCK_ERASE = 8'h20;
  localparam logic [7:0] CMD_CHIP_ERASE = 8'h30;
  localparam logic [7:0] CMD_CONFIRM = 8'hd0;
  localparam logic [7:0] CMD_WRITE_A = 8'h40;
  localparam logic [7:0] CMD_WRITE_B = 8'h10;
  localparam int READY_BIT = 7;
  localparam int ERASE_ERR_BIT = 5;
  localparam int WRITE_ERR_BIT = 4;
  localparam int SUPPLY_BIT = 3;
  localparam int PROTECT_BIT = 1;
  localparam logic [7:0] STATUS_MASK = 8'hfe;
  localparam logic [7:0] XSTATUS_MASK = 8'h80;
  // Bus cycle timing in ns, rounded up to clock cycles at 100 MHz
  localparam int CLK_NS = 10;
  localparam int WE_LOW_NS = 50;
  localparam int WE_LOW_CYC = (WE_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int OE_LOW_NS = 100;
  localparam int OE_LOW_CYC = (OE_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int ADDR_W = 21;
  typedef enum logic [1:0] {
    OP_BLOCK_ERASE = 2'b00,
    OP_CHIP_ERASE = 2'b01,
    OP_WORD_WRITE = 2'b10,
    OP_CLEAR = 2'b11
  } op_t;
  typedef struct packed {
    logic supplyErr;
    logic protectErr;
    logic sequenceErr;
    logic eraseErr;
    logic writeErr;
  } errors_t;
endpackage : flash_ctl_pkg

// File: flash_bus_cycle.sv
// One write or read cycle on the flash parallel bus.
// Assumes the flash samples data on the rising edge of write enable.
`timescale 1ns/1ns
module flash_bus_cycle (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Request
  input wire logic start,
  input wire logic isRead,
  input wire logic [7:0] wrData,
  output logic done,
  output logic [7:0] rdData,
  // Pins
  input wire logic [7:0] dqIn,
  output logic [7:0] dqOut,
  output logic dqOe_n,
  output logic we_n,
  output logic oe_n
);
  import flash_ctl_pkg::*;
  logic [7:0] cnt_reg;
  logic busy_reg;
  logic [7:0] dqSync1_reg, dqSync2_reg;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dqSync1_reg <= 8'h00;
      dqSync2_reg <= 8'h00;
    end else begin
      dqSync1_reg <= dqIn;
      dqSync2_reg <= dqSync1_reg;
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      busy_reg <= 1'b0;
      cnt_reg <= 8'h00;
      done <= 1'b0;
      rdData <= 8'h00;
      dqOut <= 8'h00;
      dqOe_n <= 1'b1;
      we_n <= 1'b1;
      oe_n <= 1'b1;
    end else begin
      done <= 1'b0;
      if (!busy_reg && start) begin
        busy_reg <= 1'b1;
        // Read waits longer: two sync stages sit behind the pins
        cnt_reg <= isRead ? 8'(OE_LOW_CYC + 2) : 8'(WE_LOW_CYC);
        dqOut <= wrData;
        dqOe_n <= isRead;
        we_n <= isRead;
        oe_n <= !isRead;
      end else if (busy_reg) begin
        if (cnt_reg == 8'h00) begin
          busy_reg <= 1'b0;
          done <= 1'b1;
          we_n <= 1'b1;
          oe_n <= 1'b1;
          dqOe_n <= 1'b1;
          rdData <= dqSync2_reg;
        end else begin
          cnt_reg <= cnt_reg - 8'h01;
        end
      end
    end
  end
endmodule : flash_bus_cycle

// File: flash_sequencer.sv
// Host-side sequencer: issues erase/write command pairs, polls status, checks errors.
// Assumes one flash on an 8-bit bus; address is held through each operation.
`timescale 1ns/1ns
module flash_sequencer (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // User command port
  input wire logic opStart,
  input wire flash_ctl_pkg::op_t opKind,
  input wire logic [flash_ctl_pkg::ADDR_W-1:0] opAddr,
  input wire logic [7:0] opData,
  output logic opBusy,
  output logic opDone,
  output flash_ctl_pkg::errors_t opErrors,
  output logic [7:0] lastStatus,
  // Flash pins
  input wire logic [7:0] dqIn,
  input wire logic readyBusyIn,
  output logic [7:0] dqOut,
  output logic dqOe_n,
  output logic [flash_ctl_pkg::ADDR_W-1:0] addr,
  output logic we_n,
  output logic oe_n,
  output logic ce_n
);
  import flash_ctl_pkg::*;
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_CMD1 = 3'b001,
    S_CMD2 = 3'b010,
    S_POLL = 3'b011,
    S_CHECK = 3'b100,
    S_EXIT = 3'b101,
    S_FINISH = 3'b110
  } state_t;
  state_t state_reg;
  op_t kind_reg;
  logic [7:0] data_reg;
  logic cycStart_reg, cycRead_reg;
  logic [7:0] cycData_reg;
  logic cycDone;
  logic [7:0] cycRd;
  logic rbSync1_reg, rbSync2_reg;

  function automatic errors_t decode(input logic [7:0] st);
    errors_t e;
    // Checked in order supply, protection, sequence, erase, write
    e.supplyErr = st[SUPPLY_BIT];
    e.protectErr = st[PROTECT_BIT];
    e.sequenceErr = st[ERASE_ERR_BIT] & st[WRITE_ERR_BIT];
    e.eraseErr = st[ERASE_ERR_BIT] & ~st[WRITE_ERR_BIT];
    e.writeErr = st[WRITE_ERR_BIT] & ~st[ERASE_ERR_BIT];
    return e;
  endfunction : decode

  flash_bus_cycle u_cycle (
    .clk(clk),
    .reset_n(reset_n),
    .start(cycStart_reg),
    .isRead(cycRead_reg),
    .wrData(cycData_reg),
    .done(cycDone),
    .rdData(cycRd),
    .dqIn(dqIn),
    .dqOut(dqOut),
    .dqOe_n(dqOe_n),
    .we_n(we_n),
    .oe_n(oe_n)
  );

  // Ready/busy pin arrives asynchronously
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rbSync1_reg <= 1'b0;
      rbSync2_reg <= 1'b0;
    end else begin
      rbSync1_reg <= readyBusyIn;
      rbSync2_reg <= rbSync1_reg;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= S_IDLE;
      kind_reg <= OP_BLOCK_ERASE;
      data_reg <= 8'h00;
      addr <= '0;
      ce_n <= 1'b1;
      cycStart_reg <= 1'b0;
      cycRead_reg <= 1'b0;
      cycData_reg <= 8'h00;
      opBusy <= 1'b0;
      opDone <= 1'b0;
      opErrors <= '0;
      lastStatus <= 8'h00;
    end else begin
      cycStart_reg <= 1'b0;
      opDone <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          if (opStart) begin
            kind_reg <= opKind;
            data_reg <= opData;
            addr <= opAddr;
            ce_n <= 1'b0;
            opBusy <= 1'b1;
            cycStart_reg <= 1'b1;
            cycRead_reg <= 1'b0;
            state_reg <= S_CMD1;
            case (opKind)
              OP_BLOCK_ERASE: cycData_reg <= CMD_BLOCK_ERASE;
              OP_CHIP_ERASE: cycData_reg <= CMD_CHIP_ERASE;
              OP_WORD_WRITE: cycData_reg <= CMD_WRITE_A;
              default: cycData_reg <= CMD_CLEAR_STATUS;
            endcase
          end
        end
        S_CMD1: begin
          if (cycDone) begin
            cycStart_reg <= 1'b1;
            if (kind_reg == OP_CLEAR) begin
              // Error bits only drop on clear-status, then select status read
              cycData_reg <= CMD_READ_STATUS;
              state_reg <= S_EXIT;
              opErrors <= '0;
            end else begin
              cycData_reg <= (kind_reg == OP_WORD_WRITE) ? data_reg : CMD_CONFIRM;
              state_reg <= S_CMD2;
            end
          end
        end
        S_CMD2: begin
          // Device now returns status on reads
          if (cycDone) begin
            cycStart_reg <= 1'b1;
            cycRead_reg <= 1'b1;
            state_reg <= S_POLL;
          end
        end
        S_POLL: begin
          if (cycDone) begin
            // Done only when both the pin and bit 7 agree on ready
            if (cycRd[READY_BIT] && rbSync2_reg) begin
              lastStatus <= cycRd & STATUS_MASK;
              state_reg <= S_CHECK;
            end else begin
              cycStart_reg <= 1'b1;
            end
          end
        end
        S_CHECK: begin
          // Sticky on the host side too, matching the device's accumulation
          opErrors <= opErrors | decode(lastStatus);
          cycStart_reg <= 1'b1;
          cycRead_reg <= 1'b0;
          cycData_reg <= CMD_READ_ARRAY;
          state_reg <= S_EXIT;
        end
        S_EXIT: begin
          if (cycDone) begin
            state_reg <= S_FINISH;
          end
        end
        S_FINISH: begin
          ce_n <= 1'b1;
          opBusy <= 1'b0;
          opDone <= 1'b1;
          cycRead_reg <= 1'b0;
          state_reg <= S_IDLE;
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end
endmodule : flash_sequencer

// File: flash_sequencer_properties.sv
// Port-level checks on the host-side flash sequencer.
// Assumes the bench holds opKind steady while an operation runs.
`timescale 1ns/1ns
module flash_sequencer_properties import flash_ctl_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // User side
  input wire logic opStart,
  input wire flash_ctl_pkg::op_t opKind,
  input wire logic [flash_ctl_pkg::ADDR_W-1:0] opAddr,
  input wire logic [7:0] opData,
  input wire logic opBusy,
  input wire logic opDone,
  input wire flash_ctl_pkg::errors_t opErrors,
  input wire logic [7:0] lastStatus,
  // Flash side
  input wire logic [7:0] dqIn,
  input wire logic readyBusyIn,
  input wire logic [7:0] dqOut,
  input wire logic dqOe_n,
  input wire logic [flash_ctl_pkg::ADDR_W-1:0] addr,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic ce_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Kind latched at the taking edge; the bench may move opKind once done shows
  op_t kindSeen_reg;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      kindSeen_reg <= OP_BLOCK_ERASE;
    end else if (opStart && !opBusy) begin
      kindSeen_reg <= opKind;
    end
  end
  mask_reserved_a: assert property (!lastStatus[0]) else $error("reserved bit kept");
  done_pulse_a: assert property (opDone |=> !opDone) else $error("done too long");
  done_ready_a: assert property (opDone && kindSeen_reg != OP_CLEAR |-> lastStatus[7] && readyBusyIn)
    else $error("done before ready");
  take_busy_a: assert property (opStart && !opBusy |=> opBusy) else $error("start lost");
  write_drives_a: assert property (!we_n |-> !dqOe_n && !ce_n && oe_n) else $error("bad write");
  read_releases_a: assert property (!oe_n |-> dqOe_n && !ce_n) else $error("bad read");
  addr_hold_a: assert property (opBusy && $past(opBusy) |-> $stable(addr)) else $error("addr moved");
  we_width_a: assert property ($fell(we_n) |-> (!we_n)[*5]) else $error("short write");
  done_bound_a: assert property (opStart && !opBusy |-> ##[2:1000] opDone) else $error("no done");
  cover property (opDone && opErrors.sequenceErr);
  cover property (opDone && opErrors.eraseErr);
  cover property (opDone && kindSeen_reg == OP_WORD_WRITE);
endmodule : flash_sequencer_properties

bind flash_sequencer flash_sequencer_properties chk (.clk, .reset_n, .opStart, .opKind,
  .opAddr, .opData, .opBusy, .opDone, .opErrors, .lastStatus, .dqIn, .readyBusyIn,
  .dqOut, .dqOe_n, .addr, .we_n, .oe_n, .ce_n);

// File: flash_model.sv
// Behavioural flash: command decoder, status register and busy timer.
// Assumes one command byte per rising edge of write enable.
`timescale 1ns/1ns
module flash_model (
  // Bus pins
  input wire logic clk,
  input wire logic [7:0] dqOut,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic ce_n,
  output logic [7:0] dqIn,
  output logic readyBusyIn,
  // Test control
  input wire logic [7:0] fault,
  output logic [23:0] wrHist
);
  logic [7:0] sr = 8'h81;
  logic [7:0] setup = 8'h00;
  int busyCnt = 0;
  assign readyBusyIn = (busyCnt == 0);
  // Busy reads carry junk low bits; a released bus shows the inverse
  assign dqIn = (oe_n || ce_n) ? ~sr : (busyCnt != 0) ? 8'h55 : sr;
  initial wrHist = 24'h000000;
  always @(posedge we_n) begin
    if (!ce_n) begin
      wrHist <= {wrHist[15:0], dqOut};
      if (setup == 8'h40 || setup == 8'h10 || (setup[7:5] == 3'h1 && dqOut == 8'hd0)) begin
        busyCnt <= 30;
        setup <= 8'h00;
      end else if (dqOut == 8'h50) begin
        sr <= 8'h81;
      end else begin
        setup <= dqOut;
      end
    end
  end
  always @(posedge clk) begin
    if (busyCnt > 0) begin
      busyCnt <= busyCnt - 1;
    end
    // Supply and lock are judged only when a sequence ends
    if (busyCnt == 1) begin
      sr <= sr | fault | 8'h81;
    end
  end
endmodule : flash_model

// File: flash_sequencer_tb_top.sv
// Self-checking bench: runs erase, write and clear operations against the model.
// Assumes the flash model answers every bus cycle.
`timescale 1ns/1ns
module flash_sequencer_tb_top;
  import flash_ctl_pkg::*;
  logic clk = 0;
  logic reset_n = 0;
  logic opStart = 0;
  op_t opKind = OP_CLEAR;
  logic [ADDR_W-1:0] opAddr = '0;
  logic [ADDR_W-1:0] addr;
  logic [7:0] opData = 8'h00;
  logic [7:0] fault = 8'h00;
  logic [7:0] dqIn, dqOut, lastStatus, expSr, d;
  logic readyBusyIn, opBusy, opDone, dqOe_n, we_n, oe_n, ce_n;
  logic [23:0] wrHist, expHist;
  errors_t opErrors;
  int errors = 0;
  int n_compared = 0;
  int cycles = 0;
  op_t kinds[7] = '{OP_BLOCK_ERASE, OP_BLOCK_ERASE, OP_CHIP_ERASE, OP_CLEAR, OP_WORD_WRITE,
    OP_CLEAR, OP_CHIP_ERASE};
  logic [7:0] faults[7] = '{8'h00, 8'h20, 8'h0a, 8'h00, 8'h10, 8'h00, 8'h30};
  logic [4:0] expErr[7] = '{5'h00, 5'h02, 5'h1a, 5'h00, 5'h01, 5'h00, 5'h04};
  always #5 clk = ~clk;
  flash_sequencer dut (.clk, .reset_n, .opStart, .opKind, .opAddr, .opData, .opBusy, .opDone,
    .opErrors, .lastStatus, .dqIn, .readyBusyIn, .dqOut, .dqOe_n, .addr, .we_n, .oe_n, .ce_n);
  flash_model mdl (.clk, .dqOut, .we_n, .oe_n, .ce_n, .dqIn, .readyBusyIn, .fault, .wrHist);
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish
  // Start is held two edges so the second one must be ignored
  task automatic run_op(input op_t k, input logic [7:0] dat, input logic [7:0] f);
    int w;
    w = 0;
    opKind = k;
    opData = dat;
    fault = f;
    opAddr = {13'h0155, dat};
    opStart = 1;
    repeat (2) @(negedge clk);
    opStart = 0;
    while (opDone !== 1'b1 && w < 2000) begin
      @(negedge clk);
      w++;
    end
    // A hung operation is a mismatch in its own right
    if (w >= 2000) begin
      errors++;
    end
  endtask : run_op
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (2) @(negedge clk);
    reset_n = 1;
    expSr = 8'h00;
    for (int i = 0; i < 7; i++) begin
      d = 8'(8'h5a + i);
      run_op(kinds[i], d, faults[i]);
      expSr = (kinds[i] == OP_CLEAR) ? 8'h00 : (expSr | faults[i]);
      check(opErrors, expErr[i]);
      check(addr, opAddr);
      check(opBusy, 1'b0);
      check(ce_n, 1'b1);
      case (kinds[i])
        OP_BLOCK_ERASE: expHist = {8'h20, 8'hd0, 8'hff};
        OP_CHIP_ERASE: expHist = {8'h30, 8'hd0, 8'hff};
        OP_WORD_WRITE: expHist = {8'h40, d, 8'hff};
        default: expHist = {8'hff, 8'h50, 8'h70};
      endcase
      check(wrHist, expHist);
      if (kinds[i] != OP_CLEAR) begin
        check(lastStatus, 8'h80 | expSr);
      end
    end
    tally_and_finish();
  end
endmodule : flash_sequencer_tb_top
